/* File: vic_ctrl.sv */
// vectored interrupt controller with avalon-mm register slave
`timescale 1ns/1ps
module vic_ctrl
   import vic_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // request sources and core
   input wire vic_src_t src_i,
   input wire vic_core_in_t core_i,
   output vic_core_out_t core_o,
   // interrupt to the system
   output logic irq_o
);

   // every check runs on the one clock and rests while reset is held
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // software registers
   logic [NNMI-1:0] nmi_control_register; // per-source nmi gates
   logic [7:0] irq_enable_register_low; // vectors 0..5 plus global
   logic [7:0] irq_enable_register_high; // vectors 6..13
   logic [NPAIR_A-1:0] priority_low_bits_a;
   logic [NPAIR_A-1:0] priority_high_bits_a;
   logic [NVEC-NPAIR_A-1:0] priority_low_bits_b;
   logic [NVEC-NPAIR_A-1:0] priority_high_bits_b;
   // hardware state
   logic [NNMI-1:0] nmi_flag_reg; // sticky nmi source flags
   logic [NSRC-1:0] src_flag_reg; // sticky shared source flags
   logic [ISV_NMI:0] isv_reg; // in-service bit per rank
   logic [NEVT-1:0] evt_reg; // sticky events
   logic [NEVT-1:0] evt_mask_reg; // event mask
   logic [3:0] idx_reg; // index of the presented vector
   logic wait_reg; // waitrequest flop
   logic [31:0] rdata_reg; // captured read word
   logic irq_reg;
   vic_core_out_t core_reg;

   // combinational helpers
   logic [5:0] byte_addr;
   logic wr_done;
   logic rd_done;
   logic [31:0] wdata;
   logic [31:0] rd_word;
   logic [NVEC-1:0] en_vec;
   logic [NVEC-1:0] pl_vec;
   logic [NVEC-1:0] ph_vec;
   logic [NVEC-1:0] vreq;
   logic nmi_pend;
   logic [2:0] top_rank;
   logic [2:0] best_rank;
   logic [3:0] best_idx;
   logic take_ack;
   vic_core_out_t core_next;

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign core_o = core_reg;
   assign irq_o = irq_reg;

   // byte lanes to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{be[b]}};
      end
      return m;
   endfunction : be_mask

   // rank of the highest routine in service, 0 when idle
   function automatic logic [2:0] rank_of(input logic [ISV_NMI:0] isv);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 0; k <= ISV_NMI; k++) begin
         if (isv[k]) begin
            r = 3'(k + 1);
         end
      end
      return r;
   endfunction : rank_of

   // level of vector n: high bit over low bit
   function automatic logic [1:0] lvl_of(input logic [NVEC-1:0] ph,
                                         input logic [NVEC-1:0] pl,
                                         input logic [3:0] n);
      return {ph[n], pl[n]};
   endfunction : lvl_of

   // vector address of maskable vector n
   function automatic logic [15:0] addr_of(input logic [3:0] n);
      return VEC_BASE + VEC_STEP * {12'h000, n};
   endfunction : addr_of

   // bus decode: a request completes on the edge where waitrequest is low
   assign byte_addr = {avs_address_i, 2'b00};
   assign wr_done = avs_write_i & ~wait_reg;
   assign rd_done = avs_read_i & ~wait_reg;
   assign wdata = avs_writedata_i & be_mask(avs_byteenable_i);

   // level and enable vectors gathered from the register pairs
   assign en_vec = {irq_enable_register_high, irq_enable_register_low[NLOW_EN-1:0]};
   assign pl_vec = {priority_low_bits_b, priority_low_bits_a};
   assign ph_vec = {priority_high_bits_b, priority_high_bits_a};

   // a vector is pending while any of its sources is flagged
   always_comb begin
      for (int v = 0; v < NVEC; v++) begin
         vreq[v] = |(src_flag_reg & VEC_MASK[v]);
      end
   end

   // nmi pending once any gated source is flagged
   assign nmi_pend = |(nmi_flag_reg & nmi_control_register);
   assign top_rank = rank_of(isv_reg);
   assign take_ack = core_i.ack & core_reg.req;

   // arbitration: highest level first, lowest index breaks a tie
   always_comb begin
      best_rank = 3'h0;
      best_idx = 4'h0;
      // walking downward lets a lower index overwrite an equal rank
      for (int v = NVEC - 1; v >= 0; v--) begin
         if (vreq[v] && en_vec[v] && irq_enable_register_low[GLOBAL_EN]) begin
            if ({1'b0, lvl_of(ph_vec, pl_vec, 4'(v))} + 3'h1 >= best_rank) begin
               best_rank = {1'b0, lvl_of(ph_vec, pl_vec, 4'(v))} + 3'h1;
               best_idx = 4'(v);
            end
         end
      end
   end

   // offer to the core; nothing is offered in the cycle after an ack or return
   always_comb begin
      core_next = '0;
      if (nmi_pend && !isv_reg[ISV_NMI]) begin
         // the nmi needs no enable and outranks any maskable routine
         core_next.req = 1'b1;
         core_next.nmi = 1'b1;
         core_next.addr = NMI_ADDR;
      end else if (best_rank > top_rank) begin
         // equal rank never preempts; rank four is beaten only by the nmi
         core_next.req = 1'b1;
         core_next.lvl = 2'(best_rank - 3'h1);
         core_next.addr = addr_of(best_idx);
      end
      if (take_ack || core_i.reti) begin
         core_next.req = 1'b0;
      end
   end

   // presented vector register
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_reg <= '0;
         idx_reg <= 4'h0;
      end else begin
         core_reg <= core_next;
         idx_reg <= best_idx;
      end
   end

   // offer checks: idx_reg names the vector that won the cycle before
   chk_nmi_vector: assert property (
      core_reg.req && core_reg.nmi |-> core_reg.addr == NMI_ADDR)
      else $error("nmi offered at wrong address");

   chk_vec_address: assert property (
      core_reg.req && !core_reg.nmi |->
         core_reg.addr[2:0] == VEC_BASE[2:0] && core_reg.addr <= VEC_LAST)
      else $error("maskable vector address off grid");

   // the enable is taken at the winner of the previous cycle, not two back
   chk_enable_gate: assert property (
      core_reg.req && !core_reg.nmi |->
         $past(en_vec[best_idx]) && $past(irq_enable_register_low[GLOBAL_EN]))
      else $error("disabled vector offered");

   chk_level_source: assert property (
      core_reg.req && !core_reg.nmi |->
         core_reg.lvl == lvl_of($past(ph_vec), $past(pl_vec), idx_reg))
      else $error("offered level differs from priority bits");

   chk_strict_preempt: assert property (
      core_reg.req |->
         (core_reg.nmi ? RANK_NMI : {1'b0, core_reg.lvl} + 3'h1) > $past(top_rank))
      else $error("offer does not outrank the running routine");

   chk_top_level_hold: assert property (
      isv_reg[ISV_NMI] |=> !core_reg.req)
      else $error("nmi routine preempted");

   // only the nmi may break into a routine of the topmost maskable level
   chk_top_maskable_hold: assert property (
      isv_reg[ISV_NMI-1] && core_reg.req |-> core_reg.nmi)
      else $error("topmost maskable routine preempted");

   chk_nmi_wins: assert property (
      nmi_pend && !isv_reg[ISV_NMI] && !core_i.ack && !core_i.reti |=>
         core_reg.req && core_reg.nmi)
      else $error("pending nmi not offered");

   chk_offer_drop: assert property (
      take_ack |=> !core_reg.req)
      else $error("offer stands after acceptance");

   // in-service ranks: set on accept, highest cleared on return
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         isv_reg <= '0;
      end else begin
         logic [ISV_NMI:0] nxt;
         nxt = isv_reg;
         if (core_i.reti && top_rank != 3'h0) begin
            nxt[top_rank - 3'h1] = 1'b0;
         end
         if (take_ack) begin
            // record the active level until the routine returns
            if (core_reg.nmi) begin
               nxt[ISV_NMI] = 1'b1;
            end else begin
               nxt[core_reg.lvl] = 1'b1;
            end
         end
         isv_reg <= nxt;
      end
   end

   // in-service checks
   chk_accept_record: assert property (
      take_ack && !core_i.reti && !core_reg.nmi |=> isv_reg[$past(core_reg.lvl)] ##1 1'b1)
      else $error("accepted level not recorded");

   chk_return_pop: assert property (
      core_i.reti && !core_i.ack && isv_reg != '0 |=>
         $countones(isv_reg) + 1 == $countones($past(isv_reg)))
      else $error("return did not clear one level");

   // source flags: a new event wins over a write-one clear
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nmi_flag_reg <= '0;
         src_flag_reg <= '0;
      end else begin
         logic [NSRC-1:0] clr;
         logic [NNMI-1:0] nclr;
         clr = '0;
         nclr = '0;
         if (wr_done && byte_addr == OFS_SRC_LO) begin
            clr[31:0] = wdata;
         end
         if (wr_done && byte_addr == OFS_SRC_HI) begin
            clr[NSRC-1:32] = wdata[NSRC-33:0];
         end
         if (wr_done && byte_addr == OFS_NMI_FLAG) begin
            nclr = wdata[NNMI-1:0];
         end
         src_flag_reg <= (src_flag_reg & ~clr) | src_i.src;
         nmi_flag_reg <= (nmi_flag_reg & ~nclr) | src_i.nmi;
      end
   end

   // an event that meets a write-one clear must still be flagged
   chk_flag_sticky: assert property (
      |src_i.src |=> (src_flag_reg & $past(src_i.src)) == $past(src_i.src))
      else $error("source event lost against a clear");

   // control registers written by software
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nmi_control_register <= '0;
         irq_enable_register_low <= 8'h00;
         irq_enable_register_high <= 8'h00;
         priority_low_bits_a <= '0;
         priority_high_bits_a <= '0;
         priority_low_bits_b <= '0;
         priority_high_bits_b <= '0;
         evt_mask_reg <= '0;
      end else if (wr_done) begin
         case (byte_addr)
            OFS_NMI_CTRL: nmi_control_register <= wdata[NNMI-1:0];
            OFS_EN_LO: irq_enable_register_low <= wdata[7:0];
            OFS_EN_HI: irq_enable_register_high <= wdata[7:0];
            OFS_PL_A: priority_low_bits_a <= wdata[NPAIR_A-1:0];
            OFS_PH_A: priority_high_bits_a <= wdata[NPAIR_A-1:0];
            OFS_PL_B: priority_low_bits_b <= wdata[NVEC-NPAIR_A-1:0];
            OFS_PH_B: priority_high_bits_b <= wdata[NVEC-NPAIR_A-1:0];
            OFS_EVT_MASK: evt_mask_reg <= wdata[NEVT-1:0];
            default: ; // unmapped or read-only: ignored
         endcase
      end
   end

   // read word, unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (byte_addr)
         OFS_NMI_CTRL: rd_word[NNMI-1:0] = nmi_control_register;
         OFS_EN_LO: rd_word[7:0] = irq_enable_register_low;
         OFS_EN_HI: rd_word[7:0] = irq_enable_register_high;
         OFS_PL_A: rd_word[NPAIR_A-1:0] = priority_low_bits_a;
         OFS_PH_A: rd_word[NPAIR_A-1:0] = priority_high_bits_a;
         OFS_PL_B: rd_word[NVEC-NPAIR_A-1:0] = priority_low_bits_b;
         OFS_PH_B: rd_word[NVEC-NPAIR_A-1:0] = priority_high_bits_b;
         OFS_NMI_FLAG: rd_word[NNMI-1:0] = nmi_flag_reg;
         OFS_SRC_LO: rd_word = src_flag_reg[31:0];
         OFS_SRC_HI: rd_word[NSRC-33:0] = src_flag_reg[NSRC-1:32];
         OFS_SERVICE: begin
            rd_word[ISV_NMI:0] = isv_reg;
            rd_word[SVC_REQ_BIT] = core_reg.req;
            rd_word[SVC_ADDR_LSB +: 16] = core_reg.addr;
         end
         OFS_EVT: rd_word[NEVT-1:0] = evt_reg;
         OFS_EVT_MASK: rd_word[NEVT-1:0] = evt_mask_reg;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // bus handshake: one wait cycle, data captured while waitrequest is high
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else if (wr_done || rd_done) begin
         wait_reg <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         wait_reg <= 1'b0;
         rdata_reg <= rd_word;
      end
   end

   // bus check: no request waits more than one cycle
   chk_bus_wait: assert property (
      (avs_read_i || avs_write_i) && wait_reg |=> !wait_reg)
      else $error("bus answer late");

   // event status: read clears only the bits that were returned,
   // so an event landing between capture and completion survives
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         logic [NEVT-1:0] set;
         logic [NEVT-1:0] clr;
         set = '0;
         clr = '0;
         set[EVT_NMI_SRC] = |src_i.nmi;
         set[EVT_SRC] = |src_i.src;
         set[EVT_ACCEPT] = take_ack;
         set[EVT_RETURN] = core_i.reti;
         if (rd_done && byte_addr == OFS_EVT) begin
            clr = rdata_reg[NEVT-1:0];
         end
         evt_reg <= (evt_reg & ~clr) | set;
         irq_reg <= |(evt_reg & evt_mask_reg);
      end
   end

   // interrupt check: the output trails the masked status by one cycle
   chk_irq_level: assert property (
      1'b1 |=> irq_reg == |($past(evt_reg) & $past(evt_mask_reg)))
      else $error("interrupt output does not follow masked status");

endmodule : vic_ctrl

/* File: vic_pkg.sv */
// package: constants and carrier types of the vectored interrupt controller
// Overview of operation
// - one nmi line, fourteen maskable vectors
// - shared vectors; source flags readable by software
// - per-vector enable bit blocks disabled requests
// - nmi at 0073h, six gated sources
// - maskable vector n at 0003h plus 8n
// - 002Bh: timer2, divider, can0, lin shared
// - 0033h: can1, can2, two converter requests
// - 0043h: seven sources under one enable
// - four programmable levels per maskable vector
// - nmi outranks every maskable level
// - levels held in two register pairs
// - preempt only by strictly higher level
// - topmost maskable level is preempted only by the nmi
// - highest level wins among simultaneous requests
// - equal level: nmi, then vectors 0..13
package vic_pkg;
   localparam int NVEC = 14; // maskable vectors
   localparam int NSRC = 34; // maskable request sources
   localparam int NNMI = 6; // nmi sources
   // vector addresses
   localparam logic [15:0] NMI_ADDR = 16'h0073;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_LAST = 16'h006b;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   // service ranks: 0 idle, level+1 maskable, nmi on top
   localparam logic [2:0] RANK_NMI = 3'h5;
   localparam int ISV_NMI = 4; // in-service bit of the nmi
   localparam int GLOBAL_EN = 7; // master enable in the low enable register
   localparam int NLOW_EN = 6; // vectors enabled from the low enable register
   localparam int NPAIR_A = 8; // vectors covered by priority pair a
   // register byte offsets
   localparam logic [5:0] OFS_NMI_CTRL = 6'h00;
   localparam logic [5:0] OFS_EN_LO = 6'h04;
   localparam logic [5:0] OFS_EN_HI = 6'h08;
   localparam logic [5:0] OFS_PL_A = 6'h0c;
   localparam logic [5:0] OFS_PH_A = 6'h10;
   localparam logic [5:0] OFS_PL_B = 6'h14;
   localparam logic [5:0] OFS_PH_B = 6'h18;
   localparam logic [5:0] OFS_NMI_FLAG = 6'h1c;
   localparam logic [5:0] OFS_SRC_LO = 6'h20;
   localparam logic [5:0] OFS_SRC_HI = 6'h24;
   localparam logic [5:0] OFS_SERVICE = 6'h28;
   localparam logic [5:0] OFS_EVT = 6'h2c;
   localparam logic [5:0] OFS_EVT_MASK = 6'h30;
   // event bits of the status register
   localparam int EVT_NMI_SRC = 0;
   localparam int EVT_SRC = 1;
   localparam int EVT_ACCEPT = 2;
   localparam int EVT_RETURN = 3;
   localparam int NEVT = 4;
   // field positions of the service register
   localparam int SVC_REQ_BIT = 8;
   localparam int SVC_ADDR_LSB = 16;
   // source index sets of each vector, shared vectors hold several bits
   localparam logic [NSRC-1:0] VEC_MASK [NVEC] = '{
      34'h0_0000_0001, // external 0
      34'h0_0000_0002, // timer 0
      34'h0_0000_0004, // external 1
      34'h0_0000_0008, // timer 1
      34'h0_0000_0010, // serial
      34'h0_0000_01e0, // timer 2, divider, can node 0, lin
      34'h0_0000_1e00, // can nodes 1 and 2, converter 0 and 1
      34'h0_0000_2000, // sync serial
      34'h0_001f_c000, // ext 2, timer 21, rotation, serial 1, divider 1, mdu x2
      34'h0_03e0_0000, // ext 3..6, can node 3
      34'h0_0c00_0000, // capcomp node 0, can node 4
      34'h0_3000_0000, // capcomp node 1, can node 5
      34'h0_c000_0000, // capcomp node 2, can node 6
      34'h3_0000_0000 // capcomp node 3, can node 7
   };
   // request sources, same clock as the controller
   typedef struct packed {
      logic [NNMI-1:0] nmi; // watchdog, clock loop, flash, core, port, ecc
      logic [NSRC-1:0] src; // maskable sources, one pulse per event
   } vic_src_t;
   // core handshake towards the controller
   typedef struct packed {
      logic ack; // core takes the presented vector
      logic reti; // core returns from the current routine
   } vic_core_in_t;
   // vector presented to the core
   typedef struct packed {
      logic req; // a vector is offered
      logic nmi; // offered vector is the nmi
      logic [1:0] lvl; // level of a maskable vector
      logic [15:0] addr; // vector address
   } vic_core_out_t;
endpackage : vic_pkg

/* File: vic_core_model.sv */
// core-side partner model: takes offered vectors and returns from routines
`timescale 1ns/1ps
module vic_core_model
   import vic_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // controller side
   input wire vic_core_out_t offer_i,
   output vic_core_in_t core_o,
   // bench controls
   input wire logic take_i,
   input wire logic [3:0] delay_i,
   input wire logic reti_i
);
   logic [3:0] wait_reg; // cycles the current offer has been seen

   // ack after a programmable wait, like a core finishing an instruction first
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_o <= '0;
         wait_reg <= '0;
      end else begin
         core_o.ack <= 1'b0;
         // one-cycle return pulse; a request held longer pulses every other cycle
         core_o.reti <= reti_i & !core_o.reti;
         if (offer_i.req && take_i && !core_o.ack) begin
            if (wait_reg == delay_i) begin
               core_o.ack <= 1'b1;
               wait_reg <= '0;
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end else begin
            // an offer that vanishes restarts the wait
            wait_reg <= '0;
         end
      end
   end
endmodule : vic_core_model

/* File: vic_ctrl_tb.sv */
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
module vic_ctrl_tb
   import vic_pkg::*;
;
   logic ref_clk_i = 1'b0; // 25 mhz clock
   logic rst_i = 1'b1; // async reset
   logic [3:0] addr = 4'h0; // bus word address
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic wreq;
   vic_src_t src = '0; // request sources
   vic_core_in_t cin; // from the core model
   vic_core_out_t cout; // offer to the core
   logic irq;
   logic take = 1'b0; // core model may take offers
   logic [3:0] dly = 4'h0; // core model ack delay
   logic reti = 1'b0;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   vic_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf), .avs_writedata_i(wd),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .src_i(src), .core_i(cin),
      .core_o(cout), .irq_o(irq));
   vic_core_model core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .offer_i(cout),
      .core_o(cin), .take_i(take), .delay_i(dly), .reti_i(reti));

   // free-running clock
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   task conclude;
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one avalon cycle, held until waitrequest is sampled low
   task bus(input logic w, input logic [5:0] ofs, input logic [31:0] d,
            output logic [31:0] q);
      @(posedge ref_clk_i);
      addr <= ofs[5:2];
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge ref_clk_i); while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task wreg(input logic [5:0] ofs, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, ofs, d, q);
   endtask : wreg

   task pulse(input logic [NSRC-1:0] s, input logic [NNMI-1:0] n);
      @(posedge ref_clk_i);
      src <= '{nmi: n, src: s};
      @(posedge ref_clk_i);
      src <= '0;
   endtask : pulse

   // wait for an offer, compare it, then let the core model take it
   task take_offer(input logic [15:0] a, input logic n, input logic [1:0] l);
      int k;
      k = 0;
      while (cout.req !== 1'b1 && k < 40) begin
         @(posedge ref_clk_i);
         k++;
      end
      // the level field means nothing on an nmi offer
      chk({cout.req, cout.nmi, n ? 2'h0 : cout.lvl, cout.addr}, {1'b1, n, l, a});
      take <= 1'b1;
      while (cin.ack !== 1'b1 && k < 80) begin
         @(posedge ref_clk_i);
         k++;
      end
      chk(32'(cin.ack), 32'h1);
      take <= 1'b0;
   endtask : take_offer

   task none(input int c);
      repeat (c) begin
         @(posedge ref_clk_i);
         chk(32'(cout.req), 32'h0);
      end
   endtask : none

   task do_reti;
      @(posedge ref_clk_i);
      reti <= 1'b1;
      @(posedge ref_clk_i);
      reti <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
   endtask : do_reti

   // software clears every request flag
   task clr;
      wreg(OFS_SRC_LO, 32'hffff_ffff);
      wreg(OFS_SRC_HI, 32'h3);
      wreg(OFS_NMI_FLAG, 32'h3f);
   endtask : clr

   task t_reset;
      logic [31:0] q;
      chk(32'(cout), 32'h0);
      chk(32'(irq), 32'h0);
      wreg(6'h34, 32'hffff_ffff);
      bus(1'b0, 6'h34, 32'h0, q);
      chk(q, 32'h0);
   endtask : t_reset

   // every source reaches the vector that it shares
   task t_sources;
      int n;
      logic [31:0] q;
      wreg(OFS_EN_LO, 32'hbf);
      wreg(OFS_EN_HI, 32'hff);
      for (int s = 0; s < NSRC; s++) begin
         for (int v = 0; v < NVEC; v++)
            if (VEC_MASK[v][s]) n = v;
         pulse(34'h1 << s, 6'h0);
         bus(1'b0, s < 32 ? OFS_SRC_LO : OFS_SRC_HI, 32'h0, q);
         chk(q, 32'h1 << (s % 32));
         take_offer(VEC_BASE + VEC_STEP * 16'(n), 1'b0, 2'h0);
         clr;
         do_reti;
      end
   endtask : t_sources

   task t_disable;
      wreg(OFS_EN_LO, 32'hbb);
      pulse(34'h4, 6'h0);
      none(6);
      wreg(OFS_EN_LO, 32'h3f);
      none(6);
      wreg(OFS_EN_LO, 32'hbf);
      take_offer(16'h0013, 1'b0, 2'h0);
      clr;
      do_reti;
   endtask : t_disable

   task t_nmi;
      for (int k = 0; k < NNMI; k++) begin
         wreg(OFS_NMI_CTRL, 32'h3f ^ (32'h1 << k));
         pulse('0, 6'h1 << k);
         none(6);
         clr;
         wreg(OFS_NMI_CTRL, 32'h1 << k);
         pulse('0, 6'h1 << k);
         take_offer(NMI_ADDR, 1'b1, 2'h0);
         clr;
         do_reti;
      end
      wreg(OFS_NMI_CTRL, 32'h3f);
      wreg(OFS_PL_B, 32'h20);
      wreg(OFS_PH_B, 32'h20);
      pulse(34'h1_0000_0000, 6'h01);
      take_offer(NMI_ADDR, 1'b1, 2'h0);
      none(4);
      wreg(OFS_NMI_FLAG, 32'h3f);
      do_reti;
      take_offer(16'h006b, 1'b0, 2'h3);
      pulse('0, 6'h02);
      take_offer(NMI_ADDR, 1'b1, 2'h0);
      clr;
      do_reti;
      do_reti;
   endtask : t_nmi

   // levels: vec0=1, vec9=2, vec11=3, vec12=2, vec13=3
   task t_prio;
      wreg(OFS_PL_A, 32'h01);
      wreg(OFS_PL_B, 32'h28);
      wreg(OFS_PH_B, 32'h3a);
      pulse(34'h0_0020_0001, 6'h0);
      take_offer(16'h004b, 1'b0, 2'h2);
      wreg(OFS_SRC_LO, 32'h0020_0000);
      pulse(34'h0_4000_0000, 6'h0);
      none(6);
      pulse(34'h1_0000_0000, 6'h0);
      take_offer(16'h006b, 1'b0, 2'h3);
      pulse(34'h0_1000_0000, 6'h0);
      none(6);
      wreg(OFS_SRC_HI, 32'h1);
      wreg(OFS_SRC_LO, 32'h1000_0000);
      do_reti;
      none(4);
      do_reti;
      take_offer(16'h0063, 1'b0, 2'h2);
      wreg(OFS_SRC_LO, 32'h4000_0000);
      do_reti;
      take_offer(16'h0003, 1'b0, 2'h1);
      clr;
      do_reti;
      // equal level 2 from the high bits only, slow core
      wreg(OFS_PL_A, 32'h0);
      wreg(OFS_PL_B, 32'h0);
      wreg(OFS_PH_A, 32'h08);
      wreg(OFS_PH_B, 32'h10);
      dly <= 4'h3;
      pulse(34'h0_4000_0008, 6'h0);
      take_offer(16'h001b, 1'b0, 2'h2);
      wreg(OFS_SRC_LO, 32'h8);
      do_reti;
      take_offer(16'h0063, 1'b0, 2'h2);
      clr;
      do_reti;
      dly <= 4'h0;
   endtask : t_prio

   // accept event is masked, unmasked, then cleared by reading
   task t_irq;
      logic [31:0] q;
      wreg(OFS_EVT_MASK, 32'h0);
      bus(1'b0, OFS_EVT, 32'h0, q);
      pulse(34'h1, 6'h0);
      bus(1'b0, OFS_SERVICE, 32'h0, q);
      chk(q, (32'(VEC_BASE) << SVC_ADDR_LSB) | (32'h1 << SVC_REQ_BIT));
      take_offer(16'h0003, 1'b0, 2'h0);
      repeat (3) @(posedge ref_clk_i);
      chk(32'(irq), 32'h0);
      wreg(OFS_EVT_MASK, 32'h1 << EVT_ACCEPT);
      repeat (3) @(posedge ref_clk_i);
      chk(32'(irq), 32'h1);
      bus(1'b0, OFS_EVT, 32'h0, q);
      chk(q, (32'h1 << EVT_SRC) | (32'h1 << EVT_ACCEPT));
      repeat (3) @(posedge ref_clk_i);
      chk(32'(irq), 32'h0);
      clr;
      do_reti;
   endtask : t_irq

   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_sources();
      t_disable();
      t_nmi();
      t_prio();
      t_irq();
      conclude();
   end
endmodule : vic_ctrl_tb
